// [rtl/bpci_interlock.sv]
// What this block does
// - three reference inputs take level codes 0-3
// - defaults: refs one,three unipolar; two 4-20 mA
// - both refs bias function: sum forms reference
// - monitor outputs accept only codes 0,2
// - four relays, defaults run/hand/auto/fault, reassignable
// - auto mode runs only while run contact closed
// - safety open with run: status and fault
// - safety open blocks bypass except smoke purge
// - automation interlock open with run: status, alarm, timeout
// - automation interlock open blocks bypass except smoke purge
// - transfer open runs drive unless keypad bypass is selected, closed runs bypass
// - smoke purge: bypass, ignore overload and safety
// - smoke purge ignores other inputs and keys
// - smoke purge ends only on input open, power
// - seven contact inputs have selectable functions
// - keypad toggles bypass and drive mode
`timescale 1ns/1ps
`default_nettype none
`include "bpci_defines.svh"

module bpci_interlock
    import bpci_pkg::*;
#(
    parameter int DEBOUNCE_CYC = `BPCI_DEBOUNCE_CYC,
    parameter int ILOCK_TO_CYC = `BPCI_ILOCK_TO_CYC
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [`BPCI_NUM_CONTACTS-1:0] contactIn,
    input wire logic motorOverload,
    input wire bpci_keys_type keys,
    input wire logic cfgWrite,
    input wire bpci_cfg_type cfgIn,
    input wire logic loadDefaults,
    input wire logic signed [`BPCI_REF_W-1:0] analogRefOneValue,
    input wire logic signed [`BPCI_REF_W-1:0] analogRefTwoValue,
    output bpci_cfg_type cfgOut,
    output logic cfgReject,
    output logic signed [`BPCI_REF_W:0] freqRef,
    output logic driveRun,
    output logic bypassRun,
    output bpci_mode_type modeOut,
    output logic bypassSelected,
    output logic safetyOpenStatus,
    output logic safetyOpenFault,
    output logic interlockOpenStatus,
    output logic interlockOpenAlarm,
    output logic interlockTimeoutFault,
    output logic smokePurgeActive,
    output logic overloadOverride,
    output logic [`BPCI_NUM_RELAYS-1:0] relayOut
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        bpci_cfg_type cfg;
        logic cfgReject;
        bpci_mode_type mode;
        logic bypassSel;
        logic safetyFault;
        logic ilockFault;
        logic [`BPCI_ILOCK_TO_W-1:0] toCnt;
        logic signed [`BPCI_REF_W:0] freqRef;
        logic driveRun;
        logic bypassRun;
        logic safetyOpen;
        logic ilockOpen;
        logic ilockAlarm;
        logic smoke;
    } bpci_state_type;

    localparam logic [`BPCI_ILOCK_TO_W-1:0] TO_LAST = `BPCI_ILOCK_TO_W'(ILOCK_TO_CYC - 1);

    bpci_state_type st;
    bpci_state_type next_st;
    logic [`BPCI_NUM_CONTACTS-1:0] stable;
    bpci_status_type status;

    logic smokeIn;
    logic runContact;
    logic safetyOpenNow;
    logic ilockOpenNow;
    logic xferIn;
    logic runCmd;
    logic wantBypass;
    logic anyFault;
    logic runOk;

    // ----------------------------------------
    // contact decode helpers
    // ----------------------------------------
    function automatic logic fnClosed(
        input bpci_difunc_type [`BPCI_NUM_CONTACTS-1:0] sel,
        input logic [`BPCI_NUM_CONTACTS-1:0] closed,
        input bpci_difunc_type code
    );
        fnClosed = 1'b0;
        for (int i = 0; i < `BPCI_NUM_CONTACTS; i++) begin
            if (sel[i] == code && closed[i]) begin
                fnClosed = 1'b1;
            end
        end
    endfunction : fnClosed

    function automatic logic fnAssigned(
        input bpci_difunc_type [`BPCI_NUM_CONTACTS-1:0] sel,
        input bpci_difunc_type code
    );
        fnAssigned = 1'b0;
        for (int i = 0; i < `BPCI_NUM_CONTACTS; i++) begin
            if (sel[i] == code) begin
                fnAssigned = 1'b1;
            end
        end
    endfunction : fnAssigned

    function automatic bpci_cfg_type defaultCfg();
        bpci_cfg_type c;
        c = '0;
        c.refLevel[0] = bpci_level_type'(`BPCI_REF_ONE_LVL_DEF);
        c.refLevel[1] = bpci_level_type'(`BPCI_REF_TWO_LVL_DEF);
        c.refLevel[2] = bpci_level_type'(`BPCI_REF_THREE_LVL_DEF);
        c.refFunc[0] = `BPCI_REF_ONE_FUNC_DEF;
        c.refFunc[1] = `BPCI_REF_TWO_FUNC_DEF;
        c.monLevel[0] = bpci_level_type'(`BPCI_MON_LVL_DEF);
        c.monLevel[1] = bpci_level_type'(`BPCI_MON_LVL_DEF);
        c.diFunc = `BPCI_DI_FUNC_DEF;
        c.relayFunc = `BPCI_RELAY_FUNC_DEF;
        defaultCfg = c;
    endfunction : defaultCfg

    function automatic logic monLevelOk(input bpci_level_type l);
        monLevelOk = (l == BPCI_LVL_UNI) || (l == BPCI_LVL_I420);
    endfunction : monLevelOk

    // ----------------------------------------
    // contact conditioning
    // ----------------------------------------
    bpci_debounce #(
        .CNT(DEBOUNCE_CYC)
    ) u_debounce (
        .sys_clk(sys_clk),
        .srst(srst),
        .rawIn(contactIn),
        .stableOut(stable)
    );

    // ----------------------------------------
    // input functions
    // ----------------------------------------
    always_comb begin
        smokeIn = fnClosed(st.cfg.diFunc, stable, BPCI_DI_SMOKE);
        runContact = fnClosed(st.cfg.diFunc, stable, BPCI_DI_RUN);
        xferIn = fnClosed(st.cfg.diFunc, stable, BPCI_DI_XFER);
        safetyOpenNow = fnAssigned(st.cfg.diFunc, BPCI_DI_SAFETY)
            && !fnClosed(st.cfg.diFunc, stable, BPCI_DI_SAFETY);
        ilockOpenNow = fnAssigned(st.cfg.diFunc, BPCI_DI_AUTO_ILOCK)
            && !fnClosed(st.cfg.diFunc, stable, BPCI_DI_AUTO_ILOCK);
        runCmd = (st.mode == BPCI_MODE_HAND)
            || (st.mode == BPCI_MODE_AUTO && runContact);
        wantBypass = st.bypassSel || xferIn;
        anyFault = st.safetyFault || st.ilockFault;
        runOk = runCmd && !anyFault && !motorOverload;
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        next_st = st;
        next_st.cfgReject = 1'b0;
        next_st.smoke = smokeIn;
        next_st.safetyOpen = safetyOpenNow;
        next_st.ilockOpen = ilockOpenNow;

        // configuration
        if (loadDefaults) begin
            next_st.cfg = defaultCfg();
        end else if (cfgWrite) begin
            next_st.cfg.refLevel = cfgIn.refLevel;
            next_st.cfg.refFunc = cfgIn.refFunc;
            next_st.cfg.diFunc = cfgIn.diFunc;
            next_st.cfg.relayFunc = cfgIn.relayFunc;
            for (int m = 0; m < `BPCI_NUM_MONITORS; m++) begin
                if (monLevelOk(cfgIn.monLevel[m])) begin
                    next_st.cfg.monLevel[m] = cfgIn.monLevel[m];
                end
            end
            next_st.cfgReject = !monLevelOk(cfgIn.monLevel[0])
                || !monLevelOk(cfgIn.monLevel[1]);
        end

        // keypad, frozen during smoke purge
        if (!smokeIn) begin
            if (keys.off) begin
                next_st.mode = BPCI_MODE_OFF;
            end else if (keys.hand) begin
                next_st.mode = BPCI_MODE_HAND;
            end else if (keys.auto) begin
                next_st.mode = BPCI_MODE_AUTO;
            end
            if (keys.bypassToggle) begin
                next_st.bypassSel = !st.bypassSel;
            end
            if (keys.faultReset) begin
                next_st.safetyFault = 1'b0;
                next_st.ilockFault = 1'b0;
            end
        end

        // interlock supervision; a set wins over a reset key
        next_st.ilockAlarm = 1'b0;
        if (smokeIn) begin
            next_st.toCnt = '0;
        end else begin
            if (runCmd && safetyOpenNow) begin
                next_st.safetyFault = 1'b1;
            end
            if (runCmd && ilockOpenNow) begin
                next_st.ilockAlarm = 1'b1;
                if (st.toCnt >= TO_LAST) begin
                    next_st.ilockFault = 1'b1;
                end else begin
                    next_st.toCnt = st.toCnt + `BPCI_ILOCK_TO_W'(1);
                end
            end else begin
                next_st.toCnt = '0;
            end
        end

        // motor path
        if (smokeIn) begin
            next_st.bypassRun = 1'b1;
            next_st.driveRun = 1'b0;
        end else begin
            next_st.bypassRun = runOk && wantBypass
                && !safetyOpenNow
                && !ilockOpenNow;
            next_st.driveRun = runOk && !wantBypass;
        end

        // frequency reference
        if (st.cfg.refFunc[0] == `BPCI_REF_FUNC_BIAS
            && st.cfg.refFunc[1] == `BPCI_REF_FUNC_BIAS) begin
            next_st.freqRef = (`BPCI_REF_W+1)'(analogRefOneValue)
                + (`BPCI_REF_W+1)'(analogRefTwoValue);
        end else begin
            next_st.freqRef = (`BPCI_REF_W+1)'(analogRefOneValue);
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st <= '0;
            st.cfg <= defaultCfg();
            st.mode <= BPCI_MODE_OFF;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // annunciation
    // ----------------------------------------
    always_comb begin
        status.motorRun = st.driveRun || st.bypassRun;
        status.handMode = (st.mode == BPCI_MODE_HAND);
        status.autoMode = (st.mode == BPCI_MODE_AUTO);
        status.fault = st.safetyFault || st.ilockFault;
        status.bypassActive = st.bypassRun;
        status.driveActive = st.driveRun;
        status.smokeActive = st.smoke;
        status.ilockOpen = st.ilockOpen;
    end

    bpci_relay_mux u_relay (
        .sys_clk(sys_clk),
        .srst(srst),
        .relayFunc(st.cfg.relayFunc),
        .status(status),
        .relayOut(relayOut)
    );

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign cfgOut = st.cfg;
    assign cfgReject = st.cfgReject;
    assign freqRef = st.freqRef;
    assign driveRun = st.driveRun;
    assign bypassRun = st.bypassRun;
    assign modeOut = st.mode;
    assign bypassSelected = st.bypassSel;
    assign safetyOpenStatus = st.safetyOpen;
    assign safetyOpenFault = st.safetyFault;
    assign interlockOpenStatus = st.ilockOpen;
    assign interlockOpenAlarm = st.ilockAlarm;
    assign interlockTimeoutFault = st.ilockFault;
    assign smokePurgeActive = st.smoke;
    assign overloadOverride = st.smoke;

endmodule : bpci_interlock
`default_nettype wire

// [rtl/bpci_defines.svh]
`ifndef BPCI_DEFINES_SVH
`define BPCI_DEFINES_SVH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define BPCI_CLK_HZ 200000000
`define BPCI_DEBOUNCE_US 10000
`define BPCI_DEBOUNCE_CYC ((`BPCI_CLK_HZ / 1000000) * `BPCI_DEBOUNCE_US)
`define BPCI_DEBOUNCE_W 22
`define BPCI_ILOCK_TO_MS 10000
`define BPCI_ILOCK_TO_CYC ((`BPCI_CLK_HZ / 1000) * `BPCI_ILOCK_TO_MS)
`define BPCI_ILOCK_TO_W 32

// ----------------------------------------
// sizes
// ----------------------------------------
`define BPCI_NUM_CONTACTS 7
`define BPCI_NUM_REFS 3
`define BPCI_NUM_MONITORS 2
`define BPCI_NUM_RELAYS 4
`define BPCI_REF_W 16
`define BPCI_REF_FUNC_W 5

// ----------------------------------------
// reset and default values
// ----------------------------------------
`define BPCI_REF_ONE_LVL_DEF 2'h0
`define BPCI_REF_TWO_LVL_DEF 2'h2
`define BPCI_REF_THREE_LVL_DEF 2'h0
`define BPCI_MON_LVL_DEF 2'h0
`define BPCI_REF_ONE_FUNC_DEF 5'h00
`define BPCI_REF_TWO_FUNC_DEF 5'h02
`define BPCI_REF_FUNC_BIAS 5'h00
`define BPCI_DI_FUNC_DEF 21'h16c688
`define BPCI_RELAY_FUNC_DEF 12'h688

`endif

// [rtl/bpci_pkg.sv]
package bpci_pkg;

    typedef enum logic [1:0] {
        BPCI_LVL_UNI = 2'h0,
        BPCI_LVL_BIP = 2'h1,
        BPCI_LVL_I420 = 2'h2,
        BPCI_LVL_I020 = 2'h3
    } bpci_level_type;

    typedef enum logic [2:0] {
        BPCI_DI_RUN = 3'h0,
        BPCI_DI_SAFETY = 3'h1,
        BPCI_DI_AUTO_ILOCK = 3'h2,
        BPCI_DI_XFER = 3'h3,
        BPCI_DI_SMOKE = 3'h4,
        BPCI_DI_SPARE = 3'h5,
        BPCI_DI_NONE6 = 3'h6,
        BPCI_DI_NONE7 = 3'h7
    } bpci_difunc_type;

    typedef enum logic [2:0] {
        BPCI_RLY_MOTOR_RUN = 3'h0,
        BPCI_RLY_HAND = 3'h1,
        BPCI_RLY_AUTO = 3'h2,
        BPCI_RLY_FAULT = 3'h3,
        BPCI_RLY_BYPASS = 3'h4,
        BPCI_RLY_DRIVE = 3'h5,
        BPCI_RLY_SMOKE = 3'h6,
        BPCI_RLY_ILOCK_OPEN = 3'h7
    } bpci_relay_type;

    typedef enum logic [1:0] {
        BPCI_MODE_OFF = 2'h0,
        BPCI_MODE_HAND = 2'h1,
        BPCI_MODE_AUTO = 2'h2
    } bpci_mode_type;

    typedef struct packed {
        bpci_level_type [2:0] refLevel;
        logic [1:0][4:0] refFunc;
        bpci_level_type [1:0] monLevel;
        bpci_difunc_type [6:0] diFunc;
        bpci_relay_type [3:0] relayFunc;
    } bpci_cfg_type;

    typedef struct packed {
        logic hand;
        logic auto;
        logic off;
        logic faultReset;
        logic bypassToggle;
    } bpci_keys_type;

    typedef struct packed {
        logic motorRun;
        logic handMode;
        logic autoMode;
        logic fault;
        logic bypassActive;
        logic driveActive;
        logic smokeActive;
        logic ilockOpen;
    } bpci_status_type;

endpackage : bpci_pkg

// [rtl/bpci_debounce.sv]
`timescale 1ns/1ps
`default_nettype none
`include "bpci_defines.svh"

module bpci_debounce
    import bpci_pkg::*;
#(
    parameter int CNT = `BPCI_DEBOUNCE_CYC
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [`BPCI_NUM_CONTACTS-1:0] rawIn,
    output logic [`BPCI_NUM_CONTACTS-1:0] stableOut
);

    typedef struct packed {
        logic [`BPCI_NUM_CONTACTS-1:0] s1;
        logic [`BPCI_NUM_CONTACTS-1:0] s2;
        logic [`BPCI_NUM_CONTACTS-1:0] stable;
        logic [`BPCI_NUM_CONTACTS-1:0][`BPCI_DEBOUNCE_W-1:0] cnt;
    } bpci_dbstate_type;

    localparam logic [`BPCI_DEBOUNCE_W-1:0] LAST = `BPCI_DEBOUNCE_W'(CNT - 1);

    bpci_dbstate_type st;
    bpci_dbstate_type next_st;

    // ----------------------------------------
    // two-stage sync then hold-off count
    // ----------------------------------------
    always_comb begin
        next_st = st;
        next_st.s1 = rawIn;
        next_st.s2 = st.s1;
        for (int i = 0; i < `BPCI_NUM_CONTACTS; i++) begin
            if (st.s2[i] == st.stable[i]) begin
                next_st.cnt[i] = '0;
            end else if (st.cnt[i] >= LAST) begin
                next_st.cnt[i] = '0;
                next_st.stable[i] = st.s2[i];
            end else begin
                next_st.cnt[i] = st.cnt[i] + `BPCI_DEBOUNCE_W'(1);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign stableOut = st.stable;

endmodule : bpci_debounce
`default_nettype wire

// [rtl/bpci_relay_mux.sv]
`timescale 1ns/1ps
`default_nettype none
`include "bpci_defines.svh"

module bpci_relay_mux
    import bpci_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire bpci_relay_type [`BPCI_NUM_RELAYS-1:0] relayFunc,
    input wire bpci_status_type status,
    output logic [`BPCI_NUM_RELAYS-1:0] relayOut
);

    typedef struct packed {
        logic [`BPCI_NUM_RELAYS-1:0] relay;
    } bpci_rlystate_type;

    bpci_rlystate_type st;
    bpci_rlystate_type next_st;

    function automatic logic pickStatus(input bpci_relay_type f, input bpci_status_type s);
        case (f)
            BPCI_RLY_MOTOR_RUN: pickStatus = s.motorRun;
            BPCI_RLY_HAND: pickStatus = s.handMode;
            BPCI_RLY_AUTO: pickStatus = s.autoMode;
            BPCI_RLY_FAULT: pickStatus = s.fault;
            BPCI_RLY_BYPASS: pickStatus = s.bypassActive;
            BPCI_RLY_DRIVE: pickStatus = s.driveActive;
            BPCI_RLY_SMOKE: pickStatus = s.smokeActive;
            BPCI_RLY_ILOCK_OPEN: pickStatus = s.ilockOpen;
            default: pickStatus = 1'b0;
        endcase
    endfunction : pickStatus

    // ----------------------------------------
    // per relay function select
    // ----------------------------------------
    always_comb begin
        next_st = st;
        for (int i = 0; i < `BPCI_NUM_RELAYS; i++) begin
            next_st.relay[i] = pickStatus(relayFunc[i], status);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign relayOut = st.relay;

endmodule : bpci_relay_mux
`default_nettype wire

// [testbench/bpci_contact_model.sv]
`timescale 1ns/1ps
`default_nettype none

module bpci_contact_model
    import bpci_pkg::*;
#(
    parameter int LEN = 3
) (
    input wire logic sys_clk,
    input wire logic [6:0] closeReq,
    input wire logic chatterReq,
    input wire logic [6:0] chatterMask,
    output logic [6:0] contactIn
);
    // ----------------------------------------
    // contact chatter shorter than debounce
    // ----------------------------------------
    int left = 0;

    always @(posedge sys_clk) begin
        if (chatterReq) begin
            left <= LEN;
        end else if (left > 0) begin
            left <= left - 1;
        end
    end

    // interlocks stay closed unless the bench opens them
    assign contactIn = (left > 0) ? (closeReq ^ chatterMask) : closeReq;
endmodule : bpci_contact_model
`default_nettype wire

// [testbench/bpci_interlock_chk.sv]
`timescale 1ns/1ps
`default_nettype none
`include "bpci_defines.svh"

module bpci_interlock_chk
    import bpci_pkg::*;
#(
    parameter int DEBOUNCE_CYC = 4,
    parameter int ILOCK_TO_CYC = 20
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic cfgWrite,
    input wire bpci_cfg_type cfgIn,
    input wire logic loadDefaults,
    input wire logic signed [`BPCI_REF_W-1:0] analogRefOneValue,
    input wire logic signed [`BPCI_REF_W-1:0] analogRefTwoValue,
    input wire bpci_cfg_type cfgOut,
    input wire logic cfgReject,
    input wire logic signed [`BPCI_REF_W:0] freqRef,
    input wire logic driveRun,
    input wire logic bypassRun,
    input wire bpci_mode_type modeOut,
    input wire logic bypassSelected,
    input wire logic safetyOpenStatus,
    input wire logic interlockOpenStatus,
    input wire logic smokePurgeActive,
    input wire logic [`BPCI_NUM_RELAYS-1:0] relayOut
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    AST_MON_EVEN: assert property (
        (cfgOut.monLevel & 4'h5) == 4'h0)
        else $error("monitor level holds a refused code");
    AST_REJECT: assert property (
        cfgWrite && !loadDefaults |=> cfgReject == (($past(cfgIn.monLevel) & 4'h5) != 4'h0))
        else $error("reject pulse does not match written level");
    AST_NO_REJECT: assert property (
        !cfgWrite |=> !cfgReject)
        else $error("reject pulse without a write");
    AST_DEFAULTS: assert property (
        loadDefaults |=> cfgOut.refLevel == 6'h08 && cfgOut.monLevel == 4'h0)
        else $error("defaults not loaded");
    AST_BIAS_SUM: assert property (
        cfgOut.refFunc == 10'h000 && $past(cfgOut.refFunc) == 10'h000 |=>
        freqRef == $past(analogRefOneValue) + $past(analogRefTwoValue))
        else $error("bias sum wrong");
    AST_RELAY_TRACK: assert property (
        cfgOut.relayFunc == 12'h688 && $past(cfgOut.relayFunc) == 12'h688 |->
        relayOut[0] == $past(driveRun || bypassRun)
        && relayOut[1] == $past(modeOut == BPCI_MODE_HAND))
        else $error("default relays do not follow run and hand");
    AST_EXCL: assert property (
        !(driveRun && bypassRun))
        else $error("drive and bypass both running");
    AST_SMOKE_BYPASS: assert property (
        smokePurgeActive |-> bypassRun && !driveRun)
        else $error("smoke purge not in bypass");
    AST_SMOKE_HOLD: assert property (
        smokePurgeActive && $past(smokePurgeActive) |-> $stable(modeOut) && $stable(bypassSelected))
        else $error("keys acted during smoke purge");
    AST_ILOCK_BLOCK: assert property (
        interlockOpenStatus && $past(interlockOpenStatus) && !smokePurgeActive
        && !$past(smokePurgeActive) |-> !bypassRun)
        else $error("bypass runs with interlock open");
    AST_SAFETY_BLOCK: assert property (
        safetyOpenStatus && $past(safetyOpenStatus) && !smokePurgeActive
        && !$past(smokePurgeActive) |-> !bypassRun)
        else $error("bypass runs with safety open");
endmodule : bpci_interlock_chk

bind bpci_interlock bpci_interlock_chk #(
    .DEBOUNCE_CYC(DEBOUNCE_CYC),
    .ILOCK_TO_CYC(ILOCK_TO_CYC)
) chk_u (
    .sys_clk(sys_clk), .srst(srst), .cfgWrite(cfgWrite), .cfgIn(cfgIn),
    .loadDefaults(loadDefaults), .analogRefOneValue(analogRefOneValue),
    .analogRefTwoValue(analogRefTwoValue), .cfgOut(cfgOut), .cfgReject(cfgReject),
    .freqRef(freqRef), .driveRun(driveRun), .bypassRun(bypassRun), .modeOut(modeOut),
    .bypassSelected(bypassSelected), .safetyOpenStatus(safetyOpenStatus),
    .interlockOpenStatus(interlockOpenStatus), .smokePurgeActive(smokePurgeActive),
    .relayOut(relayOut)
);
`default_nettype wire

// [testbench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end

module testbench
    import bpci_pkg::*;
;
    localparam int DEB = 4;
    localparam int ITO = 20;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [6:0] closeReq = 7'h06;
    logic chatterReq = 1'b0;
    logic [6:0] chatterMask = 7'h00;
    logic [6:0] contactIn;
    logic motorOverload = 1'b0;
    bpci_keys_type keys = '0;
    logic cfgWrite = 1'b0;
    logic loadDefaults = 1'b0;
    bpci_cfg_type cfgIn = '0;
    bpci_cfg_type cfgOut;
    bpci_cfg_type c;
    bpci_cfg_type defCfg = {6'h08, 10'h040, 4'h0, 21'h16c688, 12'h688};
    logic signed [15:0] refOne = '0;
    logic signed [15:0] refTwo = '0;
    logic signed [16:0] freqRef;
    logic cfgReject, driveRun, bypassRun, bypassSelected, overloadOverride;
    logic safetyOpenStatus, safetyOpenFault, interlockOpenStatus;
    logic interlockTimeoutFault, smokePurgeActive, interlockOpenAlarm;
    bpci_mode_type modeOut;
    logic [3:0] relayOut;
    int failures = 0;
    int compares = 0;

    bpci_contact_model #(.LEN(DEB - 1)) model_u (.sys_clk(sys_clk), .closeReq(closeReq),
        .chatterReq(chatterReq), .chatterMask(chatterMask), .contactIn(contactIn));

    bpci_interlock #(.DEBOUNCE_CYC(DEB), .ILOCK_TO_CYC(ITO)) dut_u (.sys_clk(sys_clk),
        .srst(srst), .contactIn(contactIn), .motorOverload(motorOverload), .keys(keys),
        .cfgWrite(cfgWrite), .cfgIn(cfgIn), .loadDefaults(loadDefaults),
        .analogRefOneValue(refOne), .analogRefTwoValue(refTwo), .cfgOut(cfgOut),
        .cfgReject(cfgReject), .freqRef(freqRef), .driveRun(driveRun), .bypassRun(bypassRun),
        .modeOut(modeOut), .bypassSelected(bypassSelected),
        .safetyOpenStatus(safetyOpenStatus), .safetyOpenFault(safetyOpenFault),
        .interlockOpenStatus(interlockOpenStatus), .interlockOpenAlarm(interlockOpenAlarm),
        .interlockTimeoutFault(interlockTimeoutFault), .smokePurgeActive(smokePurgeActive),
        .overloadOverride(overloadOverride), .relayOut(relayOut));

    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick

    task automatic press(input logic [4:0] k);
        keys = k;
        tick(1);
        keys = '0;
        tick(3);
    endtask : press

    task automatic write(input bpci_cfg_type v);
        cfgIn = v;
        cfgWrite = 1'b1;
        tick(1);
        cfgWrite = 1'b0;
    endtask : write

    task automatic defaults();
        loadDefaults = 1'b1;
        tick(1);
        loadDefaults = 1'b0;
    endtask : defaults

    task automatic contacts(input logic [6:0] v);
        closeReq = v;
        tick(DEB + 7);
    endtask : contacts

    task automatic chatter(input logic [6:0] m);
        chatterMask = m;
        chatterReq = 1'b1;
        tick(1);
        chatterReq = 1'b0;
        tick(DEB + 7);
    endtask : chatter

    task automatic conclude();
        if (failures == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial forever #2.5 sys_clk = ~sys_clk;

    initial begin
        #(5 * 3000);
        failures++;
        conclude();
    end

    initial begin
        tick(6);
        srst = 1'b0;
        tick(DEB + 7);
        `CHK(cfgOut, defCfg)
        `CHK({safetyOpenStatus, interlockOpenStatus, relayOut}, 6'h00)
        for (int i = 0; i < 4; i++) begin
            c = defCfg;
            c.refLevel = {3{bpci_level_type'(i)}};
            c.monLevel = {2{bpci_level_type'(i)}};
            write(c);
            `CHK(cfgOut.refLevel, c.refLevel)
            `CHK(cfgReject, i[0])
            `CHK(cfgOut.monLevel, {2{bpci_level_type'(i & 2)}})
            tick(1);
        end
        `CHK(cfgReject, 1'b0)
        defaults();
        `CHK(cfgOut, defCfg)
        c = defCfg;
        c.refFunc = '0;
        write(c);
        refOne = 16'sh7fff;
        refTwo = 16'sh7fff;
        tick(2);
        `CHK(freqRef, 17'h0fffe)
        refOne = 16'sh8000;
        refTwo = 16'sh8000;
        tick(2);
        `CHK(freqRef, 17'h10000)
        defaults();
        tick(2);
        `CHK(freqRef, 17'h18000)
        press(5'h10);
        `CHK({driveRun, bypassRun, modeOut, relayOut}, {2'b10, BPCI_MODE_HAND, 4'h3})
        chatter(7'h08);
        `CHK(bypassRun, 1'b0)
        contacts(7'h0e);
        `CHK({driveRun, bypassRun, relayOut[0]}, 3'b011)
        contacts(7'h0a);
        `CHK({bypassRun, interlockOpenStatus, interlockOpenAlarm}, 3'b011)
        tick(ITO);
        `CHK({interlockTimeoutFault, relayOut[3]}, 2'b11)
        contacts(7'h0e);
        press(5'h02);
        `CHK({interlockTimeoutFault, interlockOpenStatus, interlockOpenAlarm}, 3'b000)
        contacts(7'h0c);
        `CHK({bypassRun, safetyOpenStatus, safetyOpenFault}, 3'b011)
        contacts(7'h06);
        press(5'h02);
        `CHK({safetyOpenFault, driveRun, bypassRun}, 3'b010)
        press(5'h01);
        `CHK({bypassSelected, driveRun, bypassRun}, 3'b101)
        press(5'h01);
        `CHK({bypassSelected, bypassRun}, 2'b00)
        press(5'h08);
        `CHK({modeOut, driveRun}, {BPCI_MODE_AUTO, 1'b0})
        contacts(7'h07);
        `CHK({driveRun, relayOut}, {1'b1, 4'h5})
        contacts(7'h06);
        `CHK(driveRun, 1'b0)
        c = defCfg;
        c.diFunc[3] = BPCI_DI_NONE6;
        c.diFunc[6] = BPCI_DI_XFER;
        c.relayFunc[0] = BPCI_RLY_BYPASS;
        c.relayFunc[1] = BPCI_RLY_DRIVE;
        c.relayFunc[2] = BPCI_RLY_SMOKE;
        c.relayFunc[3] = BPCI_RLY_ILOCK_OPEN;
        write(c);
        press(5'h10);
        contacts(7'h46);
        `CHK({bypassRun, relayOut}, 5'h11)
        contacts(7'h0e);
        `CHK({driveRun, bypassRun, relayOut}, 6'h22)
        defaults();
        motorOverload = 1'b1;
        contacts(7'h14);
        `CHK({smokePurgeActive, overloadOverride, bypassRun, driveRun}, 4'he)
        for (int k = 0; k < 5; k++) begin
            press(5'h01 << k);
            `CHK({modeOut, bypassSelected, bypassRun}, {BPCI_MODE_HAND, 2'b01})
        end
        contacts(7'h1d);
        `CHK({smokePurgeActive, bypassRun, driveRun}, 3'b110)
        chatter(7'h10);
        `CHK(smokePurgeActive, 1'b1)
        contacts(7'h06);
        `CHK({smokePurgeActive, overloadOverride}, 2'b00)
        press(5'h04);
        `CHK(modeOut, BPCI_MODE_OFF)
        motorOverload = 1'b0;
        conclude();
    end
endmodule : testbench
`default_nettype wire
